// *** verilog/rsofc_rx_cfg.v ***
`timescale 1ns/1ns
`default_nettype none
`include "rsofc_map.vh"

module rsofc_rx_cfg #(
  parameter SAMPLE_W = 8,
  parameter [7:0] TRIM_BOOT = `RSOFC_RST_TRIM,
  parameter [7:0] CLKS_SPEED0 = 8'h10,
  parameter [7:0] CLKS_SPEED1 = 8'h40,
  parameter [7:0] CLKS_SPEED2 = 8'h80
) (
  // clock and reset
  input wire core_clk,
  input wire rst_b,
  // register port
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // converter samples and correlator result
  input wire sample_valid,
  input wire [SAMPLE_W-1:0] sample_in,
  input wire corr_valid,
  input wire [SAMPLE_W-1:0] corr_in,
  input wire frame_start,
  input wire byte_start,
  // conditioned samples
  output reg shaped_valid,
  output reg [SAMPLE_W-1:0] shaped_out,
  // bit grid
  output reg grid_strobe,
  output reg resync_pulse,
  // decoded configuration
  output reg [15:0] sof_pattern_value,
  output reg [15:0] sof_pattern_mask,
  output reg [15:0] sof_collision_mask,
  output reg [3:0] pattern_valid_length,
  output reg half_length_final_bit,
  output reg [1:0] pattern_interpretation,
  output reg manchester_polarity,
  output reg fsk_select,
  output reg bpsk_select,
  output reg [1:0] subcarrier_select,
  output reg [7:0] correlation_clock_count,
  output reg [6:0] correlation_length,
  output reg [7:0] receiver_factory_trim
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  reg [7:0] pat_high_q;
  reg [7:0] pat_low_q;
  reg [7:0] sync_ctrl_q;
  reg [7:0] demod_q;
  reg [7:0] corr_q;
  reg [7:0] trim_q;

  // reserved bits dropped on write, so they read back zero
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pat_high_q <= `RSOFC_RST_PAT;
      pat_low_q <= `RSOFC_RST_PAT;
      sync_ctrl_q <= `RSOFC_RST_CTRL;
      demod_q <= `RSOFC_RST_CTRL;
      corr_q <= `RSOFC_RST_CTRL;
      trim_q <= TRIM_BOOT;
    end else if (reg_wr) begin
      case (reg_addr)
        `RSOFC_ADDR_PAT_HIGH: pat_high_q <= reg_wdata;
        `RSOFC_ADDR_PAT_LOW: pat_low_q <= reg_wdata;
        `RSOFC_ADDR_SYNC_CTRL: sync_ctrl_q <= reg_wdata;
        `RSOFC_ADDR_DEMOD_CTRL: demod_q <= reg_wdata & `RSOFC_DEMOD_MASK;
        `RSOFC_ADDR_CORR_CTRL: corr_q <= reg_wdata & `RSOFC_CORR_MASK;
        `RSOFC_ADDR_TRIM: trim_q <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // boot trim loaded once after reset release
  reg trim_loaded_q;
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      trim_loaded_q <= 1'b0;
    end else begin
      trim_loaded_q <= 1'b1;
    end
  end

  // trim shows the boot value until the first edge after reset
  wire [7:0] trim_eff;
  assign trim_eff = trim_loaded_q ? trim_q : TRIM_BOOT;

  ////////////////////////////////////////////////////////////////////////////
  // read path
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `RSOFC_ADDR_PAT_HIGH: reg_rdata <= pat_high_q;
        `RSOFC_ADDR_PAT_LOW: reg_rdata <= pat_low_q;
        `RSOFC_ADDR_SYNC_CTRL: reg_rdata <= sync_ctrl_q;
        `RSOFC_ADDR_DEMOD_CTRL: reg_rdata <= demod_q;
        `RSOFC_ADDR_CORR_CTRL: reg_rdata <= corr_q;
        `RSOFC_ADDR_TRIM: reg_rdata <= trim_eff;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // field decode
  wire [3:0] len_f = sync_ctrl_q[`RSOFC_SYNC_LEN_HI:`RSOFC_SYNC_LEN_LO];
  wire [1:0] type_f = sync_ctrl_q[`RSOFC_SYNC_TYPE_HI:`RSOFC_SYNC_TYPE_LO];
  wire negedge_f = sync_ctrl_q[`RSOFC_SYNC_NEGEDGE_BIT];
  wire avg_f = demod_q[`RSOFC_DEMOD_AVG_BIT];
  wire square_f = demod_q[`RSOFC_DEMOD_SQUARE_BIT];
  wire peak_f = demod_q[`RSOFC_DEMOD_PEAK_BIT];
  wire [1:0] speed_f = corr_q[`RSOFC_CORR_SPEED_HI:`RSOFC_CORR_SPEED_LO];
  wire [15:0] pat_w = {pat_high_q, pat_low_q};

  // mask of the lowest n pattern bits
  function [15:0] low_mask;
    input [4:0] n;
    integer i;
    begin
      low_mask = 16'h0000;
      for (i = 0; i < 16; i = i + 1) begin
        if (i < n) begin
          low_mask[i] = 1'b1;
        end
      end
    end
  endfunction

  // per pair {data, coll}: collision clears data compare
  function [15:0] coll_bits;
    input [15:0] p;
    integer k;
    begin
      coll_bits = 16'h0000;
      for (k = 0; k < 8; k = k + 1) begin
        coll_bits[2*k] = p[2*k];
        coll_bits[2*k+1] = p[2*k];
      end
    end
  endfunction

  reg [15:0] mask_d;
  reg [15:0] coll_d;
  reg [15:0] value_d;
  always @* begin
    mask_d = 16'h0000;
    coll_d = 16'h0000;
    value_d = pat_w;
    case (type_f)
      `RSOFC_TYPE_BURST: begin
        mask_d = (len_f == 4'h0) ? 16'hFFFF : low_mask({1'b0, len_f});
      end
      `RSOFC_TYPE_NIBBLE: begin
        coll_d = coll_bits(pat_w);
        mask_d = low_mask({1'b0, len_f}) & ~coll_d;
        value_d = pat_w & ~coll_d;
      end
      `RSOFC_TYPE_START_BIT: begin
        mask_d = 16'h0000;
      end
      default: begin
        // reserved type 3: nothing to match
        mask_d = 16'h0000;
      end
    endcase
  end

  reg [7:0] clks_d;
  always @* begin
    case (speed_f)
      2'h0: clks_d = CLKS_SPEED0;
      2'h1: clks_d = CLKS_SPEED1;
      2'h2: clks_d = CLKS_SPEED2;
      // reserved speed behaves as speed 0
      default: clks_d = CLKS_SPEED0;
    endcase
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sof_pattern_value <= 16'h0000;
      sof_pattern_mask <= 16'h0000;
      sof_collision_mask <= 16'h0000;
      pattern_valid_length <= 4'h0;
      half_length_final_bit <= 1'b0;
      pattern_interpretation <= 2'h0;
      manchester_polarity <= 1'b0;
      fsk_select <= 1'b0;
      bpsk_select <= 1'b0;
      subcarrier_select <= 2'h0;
      correlation_clock_count <= 8'h00;
      correlation_length <= `RSOFC_CORR_LEN_LONG;
      receiver_factory_trim <= TRIM_BOOT;
    end else begin
      sof_pattern_value <= value_d;
      sof_pattern_mask <= mask_d;
      sof_collision_mask <= coll_d;
      pattern_valid_length <= len_f;
      half_length_final_bit <= sync_ctrl_q[`RSOFC_SYNC_HALF_BIT];
      pattern_interpretation <= type_f;
      manchester_polarity <= demod_q[`RSOFC_DEMOD_POL_BIT];
      fsk_select <= demod_q[`RSOFC_DEMOD_FSK_BIT];
      bpsk_select <= demod_q[`RSOFC_DEMOD_BPSK_BIT];
      subcarrier_select <= corr_q[`RSOFC_CORR_FREQ_HI:`RSOFC_CORR_FREQ_LO];
      correlation_clock_count <= clks_d;
      correlation_length <= corr_q[`RSOFC_CORR_SHORT_BIT] ?
                            `RSOFC_CORR_LEN_SHORT : `RSOFC_CORR_LEN_LONG;
      receiver_factory_trim <= trim_eff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample conditioning
  reg [SAMPLE_W+1:0] acc_q;
  reg [1:0] acc_cnt_q;
  wire [SAMPLE_W+1:0] acc_sum = acc_q + {2'b00, sample_in};
  wire [SAMPLE_W-1:0] avg_val = acc_sum[SAMPLE_W+1:2];

  // push toward rails: midscale and above goes to max, below to zero
  function [SAMPLE_W-1:0] square_up;
    input [SAMPLE_W-1:0] s;
    begin
      square_up = s[SAMPLE_W-1] ? {SAMPLE_W{1'b1}} : {SAMPLE_W{1'b0}};
    end
  endfunction

  // optional rail shaping of one conditioned value
  function [SAMPLE_W-1:0] shape_val;
    input sq;
    input [SAMPLE_W-1:0] s;
    begin
      shape_val = sq ? square_up(s) : s;
    end
  endfunction

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_q <= {(SAMPLE_W+2){1'b0}};
      acc_cnt_q <= 2'h0;
      shaped_valid <= 1'b0;
      shaped_out <= {SAMPLE_W{1'b0}};
    end else begin
      shaped_valid <= 1'b0;
      if (sample_valid) begin
        if (avg_f) begin
          acc_cnt_q <= acc_cnt_q + 2'h1;
          if (acc_cnt_q == 2'h3) begin
            acc_q <= {(SAMPLE_W+2){1'b0}};
            shaped_valid <= 1'b1;
            shaped_out <= shape_val(square_f, avg_val);
          end else begin
            acc_q <= acc_sum;
          end
        end else begin
          // averaging restarts on each sample taken while the filter is off
          acc_cnt_q <= 2'h0;
          acc_q <= {(SAMPLE_W+2){1'b0}};
          shaped_valid <= 1'b1;
          shaped_out <= shape_val(square_f, sample_in);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bit grid placement
  reg [SAMPLE_W-1:0] corr_prev_q;
  // direction of the last correlation step
  reg rising_q;
  reg first_fall_q;
  wire corr_up = corr_in > corr_prev_q;
  wire corr_down = corr_in < corr_prev_q;

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      corr_prev_q <= {SAMPLE_W{1'b0}};
      rising_q <= 1'b0;
      first_fall_q <= 1'b0;
      grid_strobe <= 1'b0;
      resync_pulse <= 1'b0;
    end else begin
      grid_strobe <= 1'b0;
      resync_pulse <= byte_start &&
        (pattern_interpretation == `RSOFC_TYPE_START_BIT);
      if (frame_start) begin
        first_fall_q <= 1'b0;
      end
      if (corr_valid) begin
        corr_prev_q <= corr_in;
        if (corr_up) begin
          rising_q <= 1'b1;
        end else if (corr_down) begin
          rising_q <= 1'b0;
        end
        if (negedge_f) begin
          // a fall in the re-arm cycle does not count once a fall has been seen
          if (corr_down && !first_fall_q) begin
            grid_strobe <= 1'b1;
            first_fall_q <= 1'b1;
          end
        end else if (peak_f) begin
          grid_strobe <= rising_q && corr_down;
        end else begin
          grid_strobe <= !rising_q && corr_up;
        end
      end
    end
  end

endmodule // rsofc_rx_cfg
`default_nettype wire

// *** inc/rsofc_map.vh ***
`ifndef RSOFC_MAP_VH
`define RSOFC_MAP_VH
// register addresses
`define RSOFC_ADDR_PAT_HIGH 8'h5A
`define RSOFC_ADDR_PAT_LOW 8'h5B
`define RSOFC_ADDR_SYNC_CTRL 8'h5C
`define RSOFC_ADDR_DEMOD_CTRL 8'h5D
`define RSOFC_ADDR_CORR_CTRL 8'h5E
`define RSOFC_ADDR_TRIM 8'h5F
// sync control fields
`define RSOFC_SYNC_LEN_HI 7
`define RSOFC_SYNC_LEN_LO 4
`define RSOFC_SYNC_NEGEDGE_BIT 3
`define RSOFC_SYNC_HALF_BIT 2
`define RSOFC_SYNC_TYPE_HI 1
`define RSOFC_SYNC_TYPE_LO 0
`define RSOFC_TYPE_BURST 2'h0
`define RSOFC_TYPE_NIBBLE 2'h1
`define RSOFC_TYPE_START_BIT 2'h2
// demod control fields
`define RSOFC_DEMOD_AVG_BIT 5
`define RSOFC_DEMOD_SQUARE_BIT 4
`define RSOFC_DEMOD_PEAK_BIT 3
`define RSOFC_DEMOD_POL_BIT 2
`define RSOFC_DEMOD_FSK_BIT 1
`define RSOFC_DEMOD_BPSK_BIT 0
`define RSOFC_DEMOD_MASK 8'h3F
// correlator control fields
`define RSOFC_CORR_FREQ_HI 7
`define RSOFC_CORR_FREQ_LO 6
`define RSOFC_CORR_SPEED_HI 5
`define RSOFC_CORR_SPEED_LO 4
`define RSOFC_CORR_SHORT_BIT 3
`define RSOFC_CORR_MASK 8'hF8
`define RSOFC_CORR_LEN_LONG 7'h40
`define RSOFC_CORR_LEN_SHORT 7'h20
// reset values
`define RSOFC_RST_PAT 8'h00
`define RSOFC_RST_CTRL 8'h00
`define RSOFC_RST_TRIM 8'h00
`endif

// *** dv/rsofc_rx_cfg_sva.sv ***
`timescale 1ns/1ns
`default_nettype none
module rsofc_rx_cfg_chk #(
  parameter [7:0] CLKS_SPEED1 = 8'h40
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // grid and decoded configuration
  input wire logic byte_start,
  input wire logic resync_pulse,
  input wire logic [15:0] sof_pattern_value,
  input wire logic [3:0] pattern_valid_length,
  input wire logic half_length_final_bit,
  input wire logic [1:0] pattern_interpretation,
  input wire logic manchester_polarity,
  input wire logic fsk_select,
  input wire logic bpsk_select,
  input wire logic [7:0] correlation_clock_count,
  input wire logic [6:0] correlation_length
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence s_wr(logic [7:0] a);
    reg_wr && reg_addr == a;
  endsequence
  chk_pat_high: assert property (s_wr(8'h5A) |-> ##2
    sof_pattern_value[15:8] == $past(reg_wdata, 2)) else $error("high byte");
  chk_pat_low: assert property (s_wr(8'h5B) |-> ##2
    sof_pattern_value[7:0] == $past(reg_wdata, 2)) else $error("low byte");
  chk_sync_fields: assert property (s_wr(8'h5C) |-> ##2
    {pattern_valid_length, half_length_final_bit, pattern_interpretation}
    == {$past(reg_wdata[7:4], 2), $past(reg_wdata[2:0], 2)})
    else $error("sync fields");
  chk_demod_bits: assert property (s_wr(8'h5D) |-> ##2
    {manchester_polarity, fsk_select, bpsk_select} == $past(reg_wdata[2:0], 2))
    else $error("demod bits");
  chk_corr_speed: assert property (s_wr(8'h5E) ##0 reg_wdata[5:4] == 2'h1
    |-> ##2 correlation_clock_count == CLKS_SPEED1) else $error("speed");
  chk_corr_len: assert property (s_wr(8'h5E) |-> ##2 correlation_length ==
    ($past(reg_wdata[3], 2) ? 7'h20 : 7'h40)) else $error("length");
  chk_resv_zero: assert property (reg_rd && reg_addr == 8'h5D |=>
    reg_rdata[7:6] == 2'h0) else $error("reserved bits");
  chk_resv_corr: assert property (reg_rd && reg_addr == 8'h5E |=>
    reg_rdata[2:0] == 3'h0) else $error("reserved corr bits");
  chk_unmapped_zero: assert property (reg_rd && (reg_addr < 8'h5A ||
    reg_addr > 8'h5F) |=> reg_rdata == 8'h00) else $error("unmapped read");
  chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  chk_resync_start: assert property (resync_pulse ==
    $past(byte_start && pattern_interpretation == 2'h2)) else $error("resync");
endmodule // rsofc_rx_cfg_chk
bind rsofc_rx_cfg rsofc_rx_cfg_chk #(.CLKS_SPEED1(CLKS_SPEED1)) u_chk (
  .core_clk(core_clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .byte_start(byte_start), .resync_pulse(resync_pulse),
  .sof_pattern_value(sof_pattern_value),
  .pattern_valid_length(pattern_valid_length),
  .half_length_final_bit(half_length_final_bit),
  .pattern_interpretation(pattern_interpretation),
  .manchester_polarity(manchester_polarity), .fsk_select(fsk_select),
  .bpsk_select(bpsk_select), .correlation_clock_count(correlation_clock_count),
  .correlation_length(correlation_length));
`default_nettype wire

// *** dv/rsofc_card_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module rsofc_card_model (
  // clock and request
  input wire logic core_clk,
  input wire logic send,
  input wire logic [7:0] level,
  // converter samples
  output logic sample_valid,
  output logic [7:0] sample_in
);
  initial begin
    sample_valid = 1'b0;
    sample_in = 8'hA5;
    forever begin
      @(posedge core_clk);
      if (send) begin
        for (int i = 0; i < 4; i++) begin
          sample_valid <= 1'b1;
          sample_in <= level + 8'(4 * i);
          @(posedge core_clk);
          // no field between samples
          sample_valid <= 1'b0;
          sample_in <= ~sample_in;
          @(posedge core_clk);
        end
      end
    end
  end
endmodule // rsofc_card_model
`default_nettype wire

// *** dv/rsofc_rx_cfg_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module rsofc_rx_cfg_tb_top;
  localparam [7:0] S0 = 8'h10, S1 = 8'h40, S2 = 8'h80;
  logic core_clk, rst_b, reg_wr, reg_rd, byte_start, send, sv, shv, rs, hb;
  logic pol, fsk, bpsk;
  logic [7:0] reg_addr, reg_wdata, rdata, si, sho, ccnt;
  logic [15:0] pval, pmask;
  logic [3:0] plen;
  logic [1:0] ptype;
  logic [6:0] clen;
  logic [7:0] spd [3] = '{S0, S1, S2};
  logic [7:0] corr_vals [6] = '{8'h10, 8'h20, 8'h30, 8'h20, 8'h10, 8'h20};
  logic cv, fs, gs;
  logic [7:0] ci, lvl, trim;
  logic [15:0] cmask;
  logic [1:0] sc;
  int n_errors, check_count;
  rsofc_rx_cfg #(.CLKS_SPEED0(S0), .CLKS_SPEED1(S1), .CLKS_SPEED2(S2)) DUT (
    .core_clk(core_clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(rdata),
    .sample_valid(sv), .sample_in(si), .corr_valid(cv), .corr_in(ci),
    .frame_start(fs), .byte_start(byte_start), .shaped_valid(shv),
    .shaped_out(sho), .grid_strobe(gs), .resync_pulse(rs),
    .sof_pattern_value(pval), .sof_pattern_mask(pmask),
    .sof_collision_mask(cmask), .pattern_valid_length(plen),
    .half_length_final_bit(hb), .pattern_interpretation(ptype),
    .manchester_polarity(pol), .fsk_select(fsk), .bpsk_select(bpsk),
    .subcarrier_select(sc), .correlation_clock_count(ccnt),
    .correlation_length(clen), .receiver_factory_trim(trim));
  rsofc_card_model u_card (.core_clk(core_clk), .send(send), .level(lvl),
    .sample_valid(sv), .sample_in(si));
  //////////////////////////////////////////////////////////////////////////
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk_val(16'(rdata), 16'(exp));
  endtask
  task automatic samp_run(input logic [7:0] base, input logic [15:0] exp);
    @(posedge core_clk);
    send <= 1'b1;
    lvl <= base;
    @(posedge core_clk);
    send <= 1'b0;
    for (int i = 0; i < 40 && shv !== 1'b1; i++) @(negedge core_clk);
    chk_val(16'(shv), 16'h0001);
    chk_val(16'(sho), exp);
  endtask
  task automatic corr_run(input logic [15:0] exp);
    logic [15:0] hits;
    hits = '0;
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      cv <= (i < 6);
      if (i < 6) ci <= corr_vals[i];
      @(negedge core_clk);
      if (gs === 1'b1) hits++;
    end
    chk_val(hits, exp);
  endtask
  task automatic test_done;
    $display("errors=%0d checks=%0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    n_errors++;
    test_done;
  end
  initial begin
    {rst_b, reg_wr, reg_rd, byte_start, send, cv, fs} = '0;
    {reg_addr, reg_wdata, ci, lvl} = '0;
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    for (int a = 8'h5A; a < 8'h60; a++) rd(8'(a), 8'h00);
    chk_val(16'(clen), 16'h0040);
    wr(8'h5A, 8'hC3);
    wr(8'h5B, 8'h5E);
    rd(8'h5A, 8'hC3);
    rd(8'h5B, 8'h5E);
    chk_val(pval, 16'hC35E);
    for (int t = 0; t < 3; t++) begin
      wr(8'h5C, {4'h4, 2'b01, 2'(t)});
      chk_val(16'({plen, hb, ptype}), 16'({4'h4, 1'b1, 2'(t)}));
      chk_val(pmask, (t == 0) ? 16'h000F :
        (t == 1) ? 16'h0003 : 16'h0000);
      chk_val(cmask, (t == 1) ? 16'hC3FC : 16'h0000);
      chk_val(pval, (t == 1) ? 16'h0002 : 16'hC35E);
    end
    wr(8'h5C, 8'h00);
    chk_val(pmask, 16'hFFFF);
    for (int b = 0; b < 6; b++) begin
      wr(8'h5D, 8'(1 << b));
      rd(8'h5D, 8'(1 << b));
      chk_val(16'({pol, fsk, bpsk}), 16'((1 << b) & 7));
    end
    wr(8'h5D, 8'hFF);
    rd(8'h5D, 8'h3F);
    for (int s = 0; s < 3; s++) begin
      wr(8'h5E, {2'(s), 2'(s), 1'(s), 3'h7});
      rd(8'h5E, {2'(s), 2'(s), 1'(s), 3'h0});
      chk_val(16'(ccnt), 16'(spd[s]));
      chk_val(16'(clen), (s & 1) ? 16'h0020 : 16'h0040);
      chk_val(16'(sc), 16'(s));
    end
    wr(8'h60, 8'hAA);
    rd(8'h60, 8'h00);
    rd(8'h5F, 8'h00);
    chk_val(16'(trim), 16'h0000);
    wr(8'h5D, 8'h20);
    samp_run(8'h40, 16'h0046);
    wr(8'h5D, 8'h30);
    samp_run(8'hC0, 16'h00FF);
    wr(8'h5C, 8'h02);
    @(posedge core_clk);
    byte_start <= 1'b1;
    @(posedge core_clk);
    byte_start <= 1'b0;
    @(negedge core_clk);
    chk_val(16'(rs), 16'h0001);
    @(negedge core_clk);
    chk_val(16'(rs), 16'h0000);
    wr(8'h5D, 8'h08);
    corr_run(16'h0001);
    wr(8'h5D, 8'h00);
    corr_run(16'h0002);
    wr(8'h5C, 8'h08);
    corr_run(16'h0001);
    corr_run(16'h0000);
    @(posedge core_clk);
    fs <= 1'b1;
    @(posedge core_clk);
    fs <= 1'b0;
    corr_run(16'h0001);
    test_done;
  end
endmodule // rsofc_rx_cfg_tb_top
`default_nettype wire
